// ==== logic/token_decode.sv ====
// token type decoder: maps the four-bit token type field to a kind
// assumes the field comes straight from the write data for the command register
`timescale 1ns/1ps
module token_decode (
  input  wire logic [3:0]          TYPE_FIELD, // token type field
  output usb_tok_pkg::kind_e       KIND        // decoded kind
);
  // reserved patterns decode to no transaction
  wire is_out   = (TYPE_FIELD == usb_tok_pkg::TOK_OUT);   // out code
  wire is_in    = (TYPE_FIELD == usb_tok_pkg::TOK_IN);    // in code
  wire is_setup = (TYPE_FIELD == usb_tok_pkg::TOK_SETUP); // setup code
  assign KIND = is_out   ? usb_tok_pkg::KIND_OUT :
                is_in    ? usb_tok_pkg::KIND_IN :
                is_setup ? usb_tok_pkg::KIND_SETUP :
                           usb_tok_pkg::KIND_NONE;
endmodule

// ==== logic/usb_tok_regs.sv ====
// host token command, threshold and descriptor base registers
// assumes a single-cycle register port; the serial engine consumes TOKEN_*
//
// Overview of operation
// - token type 0001 OUT, 1001 IN, 1101 SETUP
// - base bits 15-9 from low page bits 7-1
// - base bits 23-16 from mid page register
// - base is 512-byte aligned, low nine zero
// - bits 31-8 read zero, writes ignored
// - all implemented bits clear on reset
// - low-speed bit selects next token speed
// - base bits 31-24 from high page register
`timescale 1ns/1ps
module usb_tok_regs (
  input  wire logic                    CLK,        // 20 MHz clock
  input  wire logic                    RESET,      // sync reset, high
  input  wire logic [7:0]              ADDR,       // byte address
  input  wire logic [31:0]             WDATA,      // write data
  input  wire logic                    WR,         // write strobe
  input  wire logic                    RD,         // read strobe
  input  wire logic                    HOST_MODE,  // host mode select
  input  wire logic                    TOKEN_DONE, // engine finished token
  output logic [31:0]                  RDATA,      // read data, next cycle
  output logic                         TOKEN_START,// one-cycle issue pulse
  output usb_tok_pkg::token_req_s      TOKEN_REQ,  // issued token details
  output logic                         TOKEN_BUSY, // token in progress
  output logic [7:0]                   THRESHOLD,  // frame start threshold
  output logic [31:0]                  BDT_BASE    // descriptor table base
);
  // stored registers
  logic [7:0]  token_ff;      // type and endpoint
  logic [7:0]  thresh_ff;     // threshold byte count
  logic [6:0]  base_low_ff;   // base bits 15-9
  logic [7:0]  base_mid_ff;   // base bits 23-16
  logic [7:0]  base_high_ff;  // base bits 31-24
  logic [7:0]  address_ff;    // low speed and device address
  logic        busy_ff;       // token outstanding
  logic        start_ff;      // issue pulse
  usb_tok_pkg::token_req_s req_ff; // latched request
  logic [31:0] rdata_ff;      // read data register

  // address decode
  wire hit_token = (ADDR == usb_tok_pkg::OFF_TOKEN);
  wire hit_thr   = (ADDR == usb_tok_pkg::OFF_THRESHOLD);
  wire hit_low   = (ADDR == usb_tok_pkg::OFF_PAGE_LOW);
  wire hit_mid   = (ADDR == usb_tok_pkg::OFF_PAGE_MID);
  wire hit_high  = (ADDR == usb_tok_pkg::OFF_PAGE_HIGH);
  wire hit_addr  = (ADDR == usb_tok_pkg::OFF_ADDRESS);
  wire hit_stat  = (ADDR == usb_tok_pkg::OFF_STATUS);

  // decoded kind of the written type field
  usb_tok_pkg::kind_e wr_kind;
  token_decode u_dec (
    .TYPE_FIELD (WDATA[usb_tok_pkg::TYPE_LSB +: 4]),
    .KIND       (wr_kind)
  );

  // a write of a valid type to the token register in host mode, with no token busy, launches a transaction
  wire issue = WR & hit_token & HOST_MODE &
               (wr_kind != usb_tok_pkg::KIND_NONE) & ~busy_ff;

  // read mux: only the low byte is implemented
  logic [7:0] rd_byte;
  assign rd_byte = hit_token ? token_ff :
                   hit_thr   ? thresh_ff :
                   hit_low   ? {base_low_ff, 1'b0} :
                   hit_mid   ? base_mid_ff :
                   hit_high  ? base_high_ff :
                   hit_addr  ? address_ff :
                   hit_stat  ? {7'h00, busy_ff} : 8'h00;
  wire [31:0] nxt_rdata = {24'h000000, rd_byte};

  // register writes; upper bits of WDATA are dropped
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      token_ff     <= usb_tok_pkg::RST_BYTE;
      thresh_ff    <= usb_tok_pkg::RST_BYTE;
      base_low_ff  <= 7'h00;
      base_mid_ff  <= usb_tok_pkg::RST_BYTE;
      base_high_ff <= usb_tok_pkg::RST_BYTE;
      address_ff   <= usb_tok_pkg::RST_BYTE;
    end
    else if (WR)
    begin
      if (hit_token) token_ff <= WDATA[7:0];
      if (hit_thr)   thresh_ff <= WDATA[7:0];
      if (hit_low)   base_low_ff <= WDATA[7:1];
      if (hit_mid)   base_mid_ff <= WDATA[7:0];
      if (hit_high)  base_high_ff <= WDATA[7:0];
      if (hit_addr)  address_ff <= WDATA[7:0];
    end
  end

  // token issue and busy tracking; issue wins over done
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      busy_ff  <= 1'b0;
      start_ff <= 1'b0;
      req_ff   <= '0;
    end
    else
    begin
      start_ff <= issue;
      if (issue)
      begin
        busy_ff <= 1'b1;
        req_ff.kind      <= wr_kind;
        req_ff.endpoint  <= WDATA[3:0];
        req_ff.low_speed <= address_ff[usb_tok_pkg::LOWSPD_BIT];
        req_ff.dev_addr  <= address_ff[6:0];
      end
      else if (TOKEN_DONE)
        busy_ff <= 1'b0;
    end
  end

  // read data register
  always_ff @(posedge CLK)
  begin
    if (RESET)
      rdata_ff <= 32'h00000000;
    else if (RD)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 32'h00000000;
  end

  // outputs
  assign RDATA       = rdata_ff;
  assign TOKEN_START = start_ff;
  assign TOKEN_REQ   = req_ff;
  assign TOKEN_BUSY  = busy_ff;
  assign THRESHOLD   = thresh_ff;
  assign BDT_BASE    = {base_high_ff, base_mid_ff, base_low_ff,
                        9'h000};

  // assertions
  base_align_a: assert property (@(posedge CLK) disable iff (RESET)
    BDT_BASE[8:0] == 9'h000) else $error("base not aligned");
  read_upper_a: assert property (@(posedge CLK) disable iff (RESET)
    RDATA[31:8] == 24'h000000) else $error("upper read bits set");
  low_bit0_a: assert property (@(posedge CLK) disable iff (RESET)
    RD && hit_low |=> RDATA[0] == 1'b0) else $error("bit0 nonzero");
  mid_write_a: assert property (@(posedge CLK) disable iff (RESET)
    WR && hit_mid |=> BDT_BASE[23:16] == $past(WDATA[7:0]))
    else $error("mid page not taken");
  high_write_a: assert property (@(posedge CLK) disable iff (RESET)
    WR && hit_high |=> BDT_BASE[31:24] == $past(WDATA[7:0]))
    else $error("high page not taken");
  issue_pulse_a: assert property (@(posedge CLK) disable iff (RESET)
    issue |=> TOKEN_START && TOKEN_BUSY ##1 !TOKEN_START)
    else $error("token not issued once");
  kind_map_a: assert property (@(posedge CLK) disable iff (RESET)
    issue && WDATA[7:4] == usb_tok_pkg::TOK_IN
    |=> TOKEN_REQ.kind == usb_tok_pkg::KIND_IN)
    else $error("in token misdecoded");
  speed_sel_a: assert property (@(posedge CLK) disable iff (RESET)
    issue |=> TOKEN_REQ.low_speed == $past(address_ff[7]))
    else $error("speed not taken");
  reset_clear_a: assert property (@(posedge CLK)
    RESET |=> THRESHOLD == 8'h00 && BDT_BASE == 32'h00000000)
    else $error("reset not clear");
  cov_issue_c: cover property (@(posedge CLK) issue);
  cov_done_c:  cover property (@(posedge CLK) TOKEN_BUSY && TOKEN_DONE);
  cov_read_c:  cover property (@(posedge CLK) RD && hit_mid);
endmodule

// ==== pkg/usb_tok_pkg.sv ====
// package: register map, field layout and types of the token/descriptor block
// assumes a plain register port with word-aligned byte offsets
package usb_tok_pkg;
  // register byte offsets (no printed offsets; one word each)
  localparam logic [7:0] OFF_TOKEN     = 8'h00;
  localparam logic [7:0] OFF_THRESHOLD = 8'h04;
  localparam logic [7:0] OFF_PAGE_LOW  = 8'h08;
  localparam logic [7:0] OFF_PAGE_MID  = 8'h0C;
  localparam logic [7:0] OFF_PAGE_HIGH = 8'h10;
  localparam logic [7:0] OFF_ADDRESS   = 8'h14;
  localparam logic [7:0] OFF_STATUS    = 8'h18;
  // reset values
  localparam logic [7:0] RST_BYTE      = 8'h00;
  // field positions
  localparam int TYPE_LSB   = 4;
  localparam int LOWSPD_BIT = 7;
  localparam int BASE_ALIGN = 9;
  // token type encodings
  localparam logic [3:0] TOK_OUT   = 4'h1;
  localparam logic [3:0] TOK_IN    = 4'h9;
  localparam logic [3:0] TOK_SETUP = 4'hD;
  // typical threshold values by packet size
  localparam logic [7:0] THR_64 = 8'h4A;
  localparam logic [7:0] THR_32 = 8'h2A;
  localparam logic [7:0] THR_16 = 8'h1A;
  localparam logic [7:0] THR_8  = 8'h12;
  // decoded token kind
  typedef enum logic [1:0] {KIND_NONE, KIND_OUT, KIND_IN, KIND_SETUP} kind_e;
  // one token request as handed to the serial engine
  typedef struct packed {
    kind_e      kind;
    logic       low_speed;
    logic [6:0] dev_addr;
    logic [3:0] endpoint;
  } token_req_s;
endpackage

// ==== verification/usb_engine_model.sv ====
// serial engine stand-in: finishes every issued token after DLY cycles
// assumes TOKEN_START is a one-cycle pulse on CLK
`timescale 1ns/1ps
module usb_engine_model #(parameter int DLY = 4) (
  input  wire logic CLK,         // module clock
  input  wire logic RESET,       // sync reset, high
  input  wire logic TOKEN_START, // issue pulse
  output logic      TOKEN_DONE   // finish pulse
);
  int cnt_ff; // cycles left on the cable
  // count the transaction down, then one done pulse
  always_ff @(posedge CLK)
  begin
    TOKEN_DONE <= 1'b0;
    if (RESET)
      cnt_ff <= 0;
    else if (TOKEN_START)
      cnt_ff <= DLY;
    else if (cnt_ff == 1)
    begin
      cnt_ff     <= 0;
      TOKEN_DONE <= 1'b1;
    end
    else if (cnt_ff > 1)
      cnt_ff <= cnt_ff - 1;
  end
endmodule

// ==== verification/usb_tok_regs_tb.sv ====
// bench for the token and descriptor base registers
// assumes the engine model closes every token
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module usb_tok_regs_tb;
  logic        CLK = 0, RESET = 1, WR = 0, RD = 0, HOST_MODE = 0;
  logic [7:0]  ADDR = 8'h00;  // byte address
  logic [31:0] WDATA = 32'h0; // write data
  logic [31:0] RDATA;         // read data
  logic        TOKEN_START, TOKEN_BUSY, TOKEN_DONE;
  usb_tok_pkg::token_req_s TOKEN_REQ; // issued token
  logic [7:0]  THRESHOLD;     // threshold out
  logic [31:0] BDT_BASE;      // table base out
  int failures = 0, checks_done = 0, cyc = 0;
  usb_tok_regs u_usb_tok_regs (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .HOST_MODE(HOST_MODE),
    .TOKEN_DONE(TOKEN_DONE), .RDATA(RDATA), .TOKEN_START(TOKEN_START),
    .TOKEN_REQ(TOKEN_REQ), .TOKEN_BUSY(TOKEN_BUSY),
    .THRESHOLD(THRESHOLD), .BDT_BASE(BDT_BASE));
  usb_engine_model u_usb_engine_model (.CLK(CLK), .RESET(RESET),
    .TOKEN_START(TOKEN_START), .TOKEN_DONE(TOKEN_DONE));
  always #25 CLK = ~CLK; // 20 MHz
  // cut a hang short
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a; WDATA <= d; WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK);
    ADDR <= a; RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 `CHK(RDATA, e)
  endtask
  // token write, expected kind k (0 = nothing starts)
  task automatic tok(input logic [3:0] ty, ep, input logic [1:0] k);
    int n;
    wr(8'h00, {24'hFFFFFF, ty, ep});
    #1 `CHK(TOKEN_START, k != 2'h0)
    if (k != 2'h0)
      `CHK(TOKEN_REQ, {k, 1'b1, 7'h05, ep})
    rd(8'h18, {31'h0, k != 2'h0});
    // software polls busy before the next token
    for (n = 0; TOKEN_BUSY === 1'b1 && n < 20; n++)
      @(posedge CLK);
    `CHK(TOKEN_BUSY, 1'b0)
    rd(8'h00, {24'h0, ty, ep});
  endtask
  task automatic reset_values();
    for (int a = 0; a < 5; a++)
      rd(8'(a * 4), 32'h0);
    `CHK(BDT_BASE, 32'h0)
  endtask
  task automatic base_regs();
    wr(8'h08, 32'hFFFFFFFF);
    wr(8'h0C, 32'hFFFFFF5A);
    wr(8'h10, 32'hAB00003C);
    wr(8'h04, 32'hFFFFFF4A);
    rd(8'h08, 32'h000000FE);
    rd(8'h0C, 32'h0000005A);
    rd(8'h10, 32'h0000003C);
    rd(8'h04, 32'h0000004A);
    rd(8'h20, 32'h0);
    `CHK(BDT_BASE, 32'h3C5AFE00)
    `CHK(THRESHOLD, 8'h4A)
  endtask
  task automatic tokens();
    wr(8'h14, 32'h00000085);
    tok(4'h9, 4'h3, 2'h0); // not host: stored only
    @(posedge CLK);
    HOST_MODE <= 1'b1;
    tok(4'h1, 4'h0, 2'h1);
    tok(4'h9, 4'h7, 2'h2);
    tok(4'hD, 4'hF, 2'h3);
    tok(4'h2, 4'h1, 2'h0);
    wr(8'h00, 32'h00000092);
    wr(8'h00, 32'h00000011);
    #1 `CHK(TOKEN_START, 1'b0)
  endtask
  initial
  begin
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    reset_values();
    base_regs();
    tokens();
    repeat (10) @(posedge CLK);
    results();
  end
endmodule
